// ===== pts_stage.sv
// Purpose: programmable threshold stage, up to three scaled magnitudes
// Assumes: meas_valid_i is a one-cycle strobe from the same clock, one per ms
// Notes:   values fixed point x10000; times in ms
//
// How it works
// - one to three channels, each compared against its own pick-up level
// - each input scaled by its multiplier; scaled value reported, clamped to 5e6
// - condition status reports normal, start, trip or blocked
// - expected operating time reported, signed, millisecond resolution
// - remaining time to trip counts down while start is active
// - ratio of each measurement to its pick-up setting reported live
// - ratio of combined magnitude to its setting reported in same range
// - pick-up level signed, step 0.0001, default 0.01
// - reset hysteresis percent of pick-up, default 3 percent
// - each channel has its own pick-up and hysteresis
// - eight comparator modes per channel, default greater-than
// - greater-than fulfilled when signed scaled value exceeds pick-up
// - absolute greater-than uses magnitude of scaled value
// - less-than fulfilled below pick-up, inhibited below blocking limit
// - absolute less-than likewise, inhibited below blocking limit
// - directional change modes: change over 20 ms beyond pick-up in set direction
// - non-directional change modes: change over 20 ms beyond pick-up either way
// - operating delay default 40 ms, release delay default 60 ms, 5 ms steps
// - pick-up while unblocked raises start; while blocked raises blocked only
// - blocking after start drops start and runs release as if pick-up cleared
// - resettable counters of start, trip and blocked occurrences
`timescale 1ns/100ps
module pts_stage
  import pts_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      meas_valid_i,
  input  wire logic        [1:0]         chan_count_i,
  input  wire logic signed [VAL_W-1:0]   measured_magnitude_one_i,
  input  wire logic signed [VAL_W-1:0]   measured_magnitude_two_i,
  input  wire logic signed [VAL_W-1:0]   measured_magnitude_three_i,
  input  wire logic signed [VAL_W-1:0]   mag_mult_one_i,
  input  wire logic signed [VAL_W-1:0]   mag_mult_two_i,
  input  wire logic signed [VAL_W-1:0]   mag_mult_three_i,
  input  wire logic signed [VAL_W-1:0]   pickup_setting_one_i,
  input  wire logic signed [VAL_W-1:0]   pickup_setting_two_i,
  input  wire logic signed [VAL_W-1:0]   pickup_setting_three_i,
  input  wire logic signed [VAL_W-1:0]   pickup_setting_calc_i,
  input  wire logic        [VAL_W-1:0]   hyst_one_i,
  input  wire logic        [VAL_W-1:0]   hyst_two_i,
  input  wire logic        [VAL_W-1:0]   hyst_three_i,
  input  wire logic signed [VAL_W-1:0]   block_lim_i,
  input  wire pts_pkg::pts_mode_t        mode_one_i,
  input  wire pts_pkg::pts_mode_t        mode_two_i,
  input  wire pts_pkg::pts_mode_t        mode_three_i,
  input  wire logic        [TIME_W-1:0]  op_delay_ms_i,
  input  wire logic        [TIME_W-1:0]  rel_delay_ms_i,
  input  wire logic                      use_defaults_i,
  input  wire logic                      block_i,
  input  wire logic                      cnt_clear_i,
  output pts_pkg::pts_cond_t             cond_o,
  output logic                           start_o,
  output logic                           trip_o,
  output logic                           blocked_o,
  output logic signed [TIME_W:0]         exp_op_time_ms_o,
  output logic        [TIME_W-1:0]       time_left_ms_o,
  output logic signed [VAL_W-1:0]        scaled_one_o,
  output logic signed [VAL_W-1:0]        scaled_two_o,
  output logic signed [VAL_W-1:0]        scaled_three_o,
  output logic signed [VAL_W-1:0]        ratio_one_o,
  output logic signed [VAL_W-1:0]        ratio_two_o,
  output logic signed [VAL_W-1:0]        ratio_three_o,
  output logic signed [VAL_W-1:0]        ratio_calc_o,
  output logic        [CNT_W-1:0]        start_cnt_o,
  output logic        [CNT_W-1:0]        trip_cnt_o,
  output logic        [CNT_W-1:0]        blocked_cnt_o
);
  import pts_pkg::*;

  // ----------------------------------------
  // input synchronisers (block and clear are pins)
  // ----------------------------------------
  logic [1:0] blk_sync_ff;
  logic [1:0] clr_sync_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_sync_ff <= '0;
      clr_sync_ff <= '0;
    end else begin
      blk_sync_ff <= {blk_sync_ff[0], block_i};
      clr_sync_ff <= {clr_sync_ff[0], cnt_clear_i};
    end
  end

  wire blk = blk_sync_ff[1];
  wire clr = clr_sync_ff[1];

  // ----------------------------------------
  // per-channel scaling, ratio and compare
  // ----------------------------------------
  wire signed [VAL_W-1:0] meas  [NCH];
  wire signed [VAL_W-1:0] mult  [NCH];
  wire signed [VAL_W-1:0] pick  [NCH];
  wire        [VAL_W-1:0] hyst  [NCH];
  pts_mode_t              mode  [NCH];
  wire signed [VAL_W-1:0] scl   [NCH];
  wire signed [VAL_W-1:0] rat   [NCH];
  wire                    met   [NCH];
  wire                    en    [NCH];

  assign meas[0] = measured_magnitude_one_i;
  assign meas[1] = measured_magnitude_two_i;
  assign meas[2] = measured_magnitude_three_i;
  assign mult[0] = mag_mult_one_i;
  assign mult[1] = mag_mult_two_i;
  assign mult[2] = mag_mult_three_i;
  assign pick[0] = use_defaults_i ? VAL_W'(PICKUP_RST) : pickup_setting_one_i;
  assign pick[1] = use_defaults_i ? VAL_W'(PICKUP_RST) : pickup_setting_two_i;
  assign pick[2] = use_defaults_i ? VAL_W'(PICKUP_RST) : pickup_setting_three_i;
  assign hyst[0] = use_defaults_i ? VAL_W'(HYST_RST) : hyst_one_i;
  assign hyst[1] = use_defaults_i ? VAL_W'(HYST_RST) : hyst_two_i;
  assign hyst[2] = use_defaults_i ? VAL_W'(HYST_RST) : hyst_three_i;
  assign mode[0] = use_defaults_i ? CMP_OVER : mode_one_i;
  assign mode[1] = use_defaults_i ? CMP_OVER : mode_two_i;
  assign mode[2] = use_defaults_i ? CMP_OVER : mode_three_i;

  function automatic logic signed [VAL_W-1:0] clamp(input logic signed [2*VAL_W-1:0] v);
    if (v > STATUS_LIM) return VAL_W'(STATUS_LIM);
    else if (v < -STATUS_LIM) return VAL_W'(-STATUS_LIM);
    else return v[VAL_W-1:0];
  endfunction

  function automatic logic signed [VAL_W-1:0] ratio(input logic signed [VAL_W-1:0] n,
                                                     input logic signed [VAL_W-1:0] d);
    logic signed [2*VAL_W-1:0] q;
    q = '0;
    if (d == '0) q = n[VAL_W-1] ? -STATUS_LIM : STATUS_LIM;
    else q = ((2*VAL_W)'(n) * FRAC_ONE) / d;
    return clamp(q);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire signed [2*VAL_W-1:0] prod = ((2*VAL_W)'(meas[g]) * mult[g]) / FRAC_ONE;
      assign scl[g] = clamp(prod);
      assign rat[g] = ratio(scl[g], pick[g]);
      assign en[g]  = (2'(g) < chan_count_i) || (g == 0);
      pts_compare u_cmp (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .eval_i      (meas_valid_i),
        .scaled_i    (scl[g]),
        .pickup_i    (pick[g]),
        .hyst_i      (hyst[g]),
        .block_lim_i (block_lim_i),
        .mode_i      (mode[g]),
        .met_o       (met[g])
      );
    end
  endgenerate

  // combined magnitude: largest enabled scaled value
  wire signed [VAL_W-1:0] c01     = (en[1] && scl[1] > scl[0]) ? scl[1] : scl[0];
  wire signed [VAL_W-1:0] calc    = (en[2] && scl[2] > c01) ? scl[2] : c01;
  wire                    pickup  = (met[0] && en[0]) || (met[1] && en[1]) || (met[2] && en[2]);

  // ----------------------------------------
  // delays
  // ----------------------------------------
  wire [TIME_W-1:0] op_dly  = use_defaults_i ? TIME_W'(OP_DELAY_RST_MS)  : op_delay_ms_i;
  wire [TIME_W-1:0] rel_dly = use_defaults_i ? TIME_W'(REL_DELAY_RST_MS) : rel_delay_ms_i;

  // ----------------------------------------
  // stage state machine
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCKED} pts_st_t;
  pts_st_t           st_ff, nxt_st;
  logic [TIME_W-1:0] op_cnt_ff, nxt_op_cnt;
  logic [TIME_W-1:0] rel_cnt_ff, nxt_rel_cnt;
  logic              rel_act_ff, nxt_rel_act;

  always_comb begin
    nxt_st      = st_ff;
    nxt_op_cnt  = op_cnt_ff;
    nxt_rel_cnt = rel_cnt_ff;
    nxt_rel_act = rel_act_ff;
    if (meas_valid_i) begin
      unique case (st_ff)
        ST_IDLE: begin
          if (pickup && blk) nxt_st = ST_BLOCKED;
          else if (pickup) begin
            nxt_st     = ST_START;
            nxt_op_cnt = op_dly;
          end
        end
        ST_BLOCKED: begin
          if (!pickup) nxt_st = ST_IDLE;
          else if (!blk) begin
            nxt_st     = ST_START;
            nxt_op_cnt = op_dly;
          end
        end
        ST_START, ST_TRIP: begin
          if (pickup && !blk) begin
            nxt_rel_act = 1'b0;
            if (st_ff == ST_START) begin
              if (op_cnt_ff <= TIME_W'(1)) begin
                nxt_st     = ST_TRIP;
                nxt_op_cnt = '0;
              end else nxt_op_cnt = op_cnt_ff - TIME_W'(1);
            end
          end else begin
            // pick-up gone or blocking arrived: run release
            if (!rel_act_ff) begin
              nxt_rel_act = 1'b1;
              nxt_rel_cnt = rel_dly;
            end
            if ((rel_act_ff && rel_cnt_ff <= TIME_W'(1)) || (!rel_act_ff && rel_dly == '0)) begin
              nxt_rel_act = 1'b0;
              nxt_op_cnt  = '0;
              nxt_st      = (pickup && blk) ? ST_BLOCKED : ST_IDLE;
            end else if (rel_act_ff) nxt_rel_cnt = rel_cnt_ff - TIME_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff      <= ST_IDLE;
      op_cnt_ff  <= '0;
      rel_cnt_ff <= '0;
      rel_act_ff <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      op_cnt_ff  <= nxt_op_cnt;
      rel_cnt_ff <= nxt_rel_cnt;
      rel_act_ff <= nxt_rel_act;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  wire start_now   = (st_ff == ST_START) && !rel_act_ff;
  wire trip_now    = (st_ff == ST_TRIP);
  wire blocked_now = (st_ff == ST_BLOCKED);
  wire start_rise  = (nxt_st == ST_START) && (st_ff != ST_START);
  wire trip_rise   = (nxt_st == ST_TRIP) && (st_ff != ST_TRIP);
  wire blk_rise    = (nxt_st == ST_BLOCKED) && (st_ff != ST_BLOCKED);

  pts_cond_t nxt_cond;
  assign nxt_cond = trip_now ? COND_TRIP : start_now ? COND_START :
                    blocked_now ? COND_BLOCKED : COND_NORMAL;

  logic [CNT_W-1:0] start_cnt_ff, trip_cnt_ff, blk_cnt_ff;
  pts_cond_t        cond_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_ff      <= COND_NORMAL;
      start_cnt_ff <= '0;
      trip_cnt_ff  <= '0;
      blk_cnt_ff   <= '0;
    end else begin
      cond_ff      <= nxt_cond;
      start_cnt_ff <= start_rise ? start_cnt_ff + CNT_W'(1) : clr ? '0 : start_cnt_ff;
      trip_cnt_ff  <= trip_rise ? trip_cnt_ff + CNT_W'(1) : clr ? '0 : trip_cnt_ff;
      blk_cnt_ff   <= blk_rise ? blk_cnt_ff + CNT_W'(1) : clr ? '0 : blk_cnt_ff;
    end
  end

  logic signed [VAL_W-1:0] scl_ff [NCH];
  logic signed [VAL_W-1:0] rat_ff [NCH];
  logic signed [VAL_W-1:0] ratc_ff;
  logic signed [TIME_W:0]  exp_ff;
  logic        [TIME_W-1:0] left_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) begin
        scl_ff[i] <= '0;
        rat_ff[i] <= '0;
      end
      ratc_ff <= '0;
      exp_ff  <= '0;
      left_ff <= '0;
    end else begin
      if (meas_valid_i) begin
        for (int i = 0; i < NCH; i++) begin
          scl_ff[i] <= en[i] ? scl[i] : '0;
          rat_ff[i] <= en[i] ? rat[i] : '0;
        end
        ratc_ff <= ratio(calc, pickup_setting_calc_i);
      end
      exp_ff  <= $signed({1'b0, op_dly});
      left_ff <= (st_ff == ST_START) ? op_cnt_ff : '0;
    end
  end

  assign cond_o           = cond_ff;
  assign start_o          = cond_ff == COND_START;
  assign trip_o           = cond_ff == COND_TRIP;
  assign blocked_o        = cond_ff == COND_BLOCKED;
  assign exp_op_time_ms_o = exp_ff;
  assign time_left_ms_o   = left_ff;
  assign scaled_one_o     = scl_ff[0];
  assign scaled_two_o     = scl_ff[1];
  assign scaled_three_o   = scl_ff[2];
  assign ratio_one_o      = rat_ff[0];
  assign ratio_two_o      = rat_ff[1];
  assign ratio_three_o    = rat_ff[2];
  assign ratio_calc_o     = ratc_ff;
  assign start_cnt_o      = start_cnt_ff;
  assign trip_cnt_o       = trip_cnt_ff;
  assign blocked_cnt_o    = blk_cnt_ff;

endmodule : pts_stage

// ===== pts_pkg.sv
// Purpose: constants and types for the programmable threshold stage
// Assumes: fixed-point values, 4 fractional decimal digits (x10000)
// Notes:   times in ms, program cycle one tick per evaluation strobe
package pts_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int VAL_W      = 48;
  localparam int TIME_W     = 22;
  localparam int CNT_W      = 16;
  localparam int NCH        = 3;

  // ----------------------------------------
  // value scaling
  // ----------------------------------------
  localparam longint FRAC_ONE       = 10000;
  localparam longint STATUS_LIM     = 5000000 * FRAC_ONE;
  localparam longint PICKUP_RST     = 100;
  localparam longint HYST_RST       = 30000;
  localparam longint PCT_FULL       = 100 * FRAC_ONE;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ             = 25000000;
  localparam int TIME_MAX_MS        = 1800000;
  localparam int TIME_STEP_MS       = 5;
  localparam int OP_DELAY_RST_MS    = 40;
  localparam int REL_DELAY_RST_MS   = 60;
  localparam int DELTA_WIN_MS       = 20;
  localparam int MS_CYC             = CLK_HZ / 1000;
  localparam int BLOCK_LEAD_MS      = 5;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMP_OVER, CMP_OVER_ABS, CMP_UNDER, CMP_UNDER_ABS,
    CMP_DSET_DIR, CMP_DSET_ABS, CMP_DVAL_DIR, CMP_DVAL_ABS
  } pts_mode_t;

  typedef enum logic [1:0] {
    COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED
  } pts_cond_t;

endpackage : pts_pkg

// ===== pts_compare.sv
// Purpose: one channel comparator with hysteresis and change detection
// Assumes: samples arrive on eval strobe, one per ms
// Notes:   holds last 20 samples for the change-over-time modes
`timescale 1ns/100ps
module pts_compare
  import pts_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      eval_i,
  input  wire logic signed [VAL_W-1:0]   scaled_i,
  input  wire logic signed [VAL_W-1:0]   pickup_i,
  input  wire logic        [VAL_W-1:0]   hyst_i,
  input  wire logic signed [VAL_W-1:0]   block_lim_i,
  input  wire pts_pkg::pts_mode_t        mode_i,
  output logic                           met_o
);
  import pts_pkg::*;

  // ----------------------------------------
  // sample history
  // ----------------------------------------
  logic signed [VAL_W-1:0] hist_ff [DELTA_WIN_MS];
  logic                    met_ff;
  logic                    nxt_met;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DELTA_WIN_MS; i++) hist_ff[i] <= '0;
    end else if (eval_i) begin
      hist_ff[0] <= scaled_i;
      for (int i = 1; i < DELTA_WIN_MS; i++) hist_ff[i] <= hist_ff[i-1];
    end
  end

  // ----------------------------------------
  // comparisons
  // ----------------------------------------
  wire signed [VAL_W-1:0] abs_val  = scaled_i[VAL_W-1] ? -scaled_i : scaled_i;
  wire signed [VAL_W-1:0] old_val  = hist_ff[DELTA_WIN_MS-1];
  wire signed [VAL_W-1:0] delta    = scaled_i - old_val;
  wire signed [VAL_W-1:0] abs_dlt  = delta[VAL_W-1] ? -delta : delta;
  wire signed [VAL_W-1:0] abs_pick = pickup_i[VAL_W-1] ? -pickup_i : pickup_i;
  wire signed [VAL_W+31:0] hyst_p  = (abs_pick * $signed({1'b0, hyst_i})) / PCT_FULL;
  wire signed [VAL_W-1:0] hyst_amt = hyst_p[VAL_W-1:0];
  wire signed [VAL_W-1:0] abs_old  = old_val[VAL_W-1] ? -old_val : old_val;
  wire signed [VAL_W+31:0] rel_p   = (abs_old * pickup_i) / PCT_FULL;
  wire signed [VAL_W-1:0] rel_lim  = rel_p[VAL_W-1:0];
  wire signed [VAL_W-1:0] rel_abs  = rel_lim[VAL_W-1] ? -rel_lim : rel_lim;
  wire signed [VAL_W-1:0] over_thr = met_ff ? pickup_i - hyst_amt : pickup_i;
  wire signed [VAL_W-1:0] undr_thr = met_ff ? pickup_i + hyst_amt : pickup_i;
  wire signed [VAL_W-1:0] dval_thr = met_ff ? pickup_i - hyst_amt : pickup_i;
  wire signed [VAL_W-1:0] dabs_thr = met_ff ? abs_pick - hyst_amt : abs_pick;
  wire signed [VAL_W-1:0] drel_thr = met_ff ? rel_abs - hyst_amt : rel_abs;
  wire                    blk_low  = scaled_i < block_lim_i;
  wire                    pick_neg = pickup_i[VAL_W-1];

  always_comb begin
    nxt_met = 1'b0;
    unique case (mode_i)
      CMP_OVER:      nxt_met = scaled_i > over_thr;
      CMP_OVER_ABS:  nxt_met = abs_val > over_thr;
      CMP_UNDER:     nxt_met = !blk_low && (scaled_i < undr_thr);
      CMP_UNDER_ABS: nxt_met = !blk_low && (abs_val < undr_thr);
      CMP_DSET_DIR:  nxt_met = pick_neg ? (delta < -drel_thr) : (delta > drel_thr);
      CMP_DSET_ABS:  nxt_met = abs_dlt > drel_thr;
      CMP_DVAL_DIR:  nxt_met = pick_neg ? (delta < dval_thr) : (delta > dval_thr);
      CMP_DVAL_ABS:  nxt_met = abs_dlt > dabs_thr;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) met_ff <= 1'b0;
    else if (eval_i) met_ff <= nxt_met;
  end

  assign met_o = met_ff;

endmodule : pts_compare

// ===== pts_meas_src.sv
// Purpose: upstream measurement source model for the threshold stage
// Assumes: one sample strobe every STROBE_GAP clock cycles
// Notes:   the sample line carries the inverted value between strobes
`timescale 1ns/100ps
module pts_meas_src
  import pts_pkg::*;
#(
  parameter int STROBE_GAP = 4
)
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic signed [VAL_W-1:0] level_i,
  output logic                         meas_valid_o,
  output logic signed [VAL_W-1:0]      sample_o
);
  import pts_pkg::*;

  logic [7:0] gap_ff;
  wire        last_w = (gap_ff == 8'(STROBE_GAP - 1));
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_ff       <= 8'h00;
      meas_valid_o <= 1'b0;
      sample_o     <= '0;
    end else begin
      gap_ff       <= last_w ? 8'h00 : gap_ff + 8'h01;
      meas_valid_o <= last_w;
      sample_o     <= last_w ? level_i : ~level_i;
    end
  end
endmodule // pts_meas_src

// ===== pts_stage_properties.sv
// Purpose: port assertions for the threshold stage
// Assumes: one clock, async active-low reset
// Notes:   bound into every pts_stage
`timescale 1ns/100ps
module pts_stage_checker
  import pts_pkg::*;
(
  input wire logic                    core_clk_i,
  input wire logic                    rst_n_i,
  input wire pts_pkg::pts_cond_t      cond_o,
  input wire logic                    start_o,
  input wire logic                    trip_o,
  input wire logic                    blocked_o,
  input wire logic signed [TIME_W:0]  exp_op_time_ms_o,
  input wire logic [TIME_W-1:0]       time_left_ms_o,
  input wire logic signed [VAL_W-1:0] scaled_one_o,
  input wire logic signed [VAL_W-1:0] ratio_calc_o,
  input wire logic [CNT_W-1:0]        start_cnt_o
);
  // --------------------------------
  // properties
  // --------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_start_dec; start_o == (cond_o == COND_START); endproperty
  a_start_dec: assert property (p_start_dec) else $error("start flag off");
  property p_trip_dec; trip_o == (cond_o == COND_TRIP); endproperty
  a_trip_dec: assert property (p_trip_dec) else $error("trip flag off");
  property p_trip_after_start; $rose(trip_o) |-> $past(start_o); endproperty
  a_trip_after_start: assert property (p_trip_after_start) else $error("trip without start");
  property p_left_falls; start_o && $past(start_o) |-> time_left_ms_o <= $past(time_left_ms_o); endproperty
  a_left_falls: assert property (p_left_falls) else $error("time left rose");
  property p_blk_no_time; blocked_o |-> time_left_ms_o == '0; endproperty
  a_blk_no_time: assert property (p_blk_no_time) else $error("timing while blocked");
  property p_cnt_step;
    start_cnt_o != $past(start_cnt_o) |-> start_cnt_o == $past(start_cnt_o) + 16'h0001 || start_cnt_o == '0;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("start count jump");
  property p_exp_range; exp_op_time_ms_o <= TIME_MAX_MS && exp_op_time_ms_o >= -TIME_MAX_MS; endproperty
  a_exp_range: assert property (p_exp_range) else $error("op time range");
  property p_scaled_range; scaled_one_o <= STATUS_LIM && scaled_one_o >= -STATUS_LIM; endproperty
  a_scaled_range: assert property (p_scaled_range) else $error("scaled range");
  property p_ratio_range; ratio_calc_o <= STATUS_LIM && ratio_calc_o >= -STATUS_LIM; endproperty
  a_ratio_range: assert property (p_ratio_range) else $error("ratio range");
endmodule // pts_stage_checker
bind pts_stage pts_stage_checker u_pts_stage_checker (
  .core_clk_i, .rst_n_i, .cond_o, .start_o, .trip_o, .blocked_o, .exp_op_time_ms_o,
  .time_left_ms_o, .scaled_one_o, .ratio_calc_o, .start_cnt_o);

// ===== pts_stage_tb.sv
// Purpose: self-checking bench for the threshold stage
// Assumes: a strobe every 4 cycles stands for one ms tick
// Notes:   short delays are set through the delay ports
`timescale 1ns/100ps
module pts_stage_tb;
  import pts_pkg::*;
  logic                    core_clk_i = 1'b0, rst_n_i = 1'b0, meas_valid, blk = 1'b0, clr = 1'b0, dflt = 1'b0;
  logic                    start, trip, blocked;
  logic [1:0]              chans = 2'h1;
  logic [TIME_W-1:0]       opd = 22'h8, reld = 22'h3, left;
  logic signed [VAL_W-1:0] level = '0, sample, mult = 48'sh2710, pick = 48'sh3E8, hyst = 48'sh7530;
  logic signed [VAL_W-1:0] blim = '0, scaled1, ratio1, ratio_c;
  logic signed [TIME_W:0]  exp_t;
  logic [CNT_W-1:0]        cnt_s, cnt_t, cnt_b;
  pts_mode_t               mode = CMP_OVER;
  pts_cond_t               cond;
  int                      num_errors = 0, checks_done = 0;
  always #20 core_clk_i = ~core_clk_i;
  pts_meas_src u_pts_meas_src (.core_clk_i, .rst_n_i, .level_i(level), .meas_valid_o(meas_valid), .sample_o(sample));
  pts_stage u_pts_stage (
    .core_clk_i, .rst_n_i, .meas_valid_i(meas_valid), .chan_count_i(chans), .measured_magnitude_one_i(sample),
    .measured_magnitude_two_i(level), .measured_magnitude_three_i(level), .mag_mult_one_i(mult),
    .mag_mult_two_i(mult), .mag_mult_three_i(mult), .pickup_setting_one_i(pick), .pickup_setting_two_i(pick),
    .pickup_setting_three_i(pick), .pickup_setting_calc_i(pick), .hyst_one_i(hyst), .hyst_two_i(hyst),
    .hyst_three_i(hyst), .block_lim_i(blim), .mode_one_i(mode), .mode_two_i(mode), .mode_three_i(mode),
    .op_delay_ms_i(opd), .rel_delay_ms_i(reld), .use_defaults_i(dflt), .block_i(blk), .cnt_clear_i(clr),
    .cond_o(cond), .start_o(start), .trip_o(trip), .blocked_o(blocked), .exp_op_time_ms_o(exp_t),
    .time_left_ms_o(left), .scaled_one_o(scaled1), .scaled_two_o(), .scaled_three_o(), .ratio_one_o(ratio1),
    .ratio_two_o(), .ratio_three_o(), .ratio_calc_o(ratio_c), .start_cnt_o(cnt_s), .trip_cnt_o(cnt_t),
    .blocked_cnt_o(cnt_b));
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wait_cond(input pts_cond_t c);
    int n;
    n = 0;
    while (cond !== c && n < 400) begin
      @(posedge core_clk_i);
      n++;
    end
    #1;
    check("cond", cond, c);
  endtask
  task automatic set_level(input logic signed [VAL_W-1:0] v);
    @(posedge core_clk_i);
    level <= v;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    set_level(48'sh4E20);
    wait_cond(COND_START);
    check("scaled", scaled1, 64'h4E20);
    check("ratio", ratio1, 64'h30D40);
    check("ratio_calc", ratio_c, 64'h30D40);
    check("exp_time", exp_t, 64'h8);
    check("time_left", left, 64'h8);
    check("start_flag", start, 64'h1);
    wait_cond(COND_TRIP);
    check("trip_flag", trip, 64'h1);
    check("time_left", left, 64'h0);
    check("trips", cnt_t, 64'h1);
    set_level(48'sh3D4);
    repeat (40) @(posedge core_clk_i);
    check("cond", cond, COND_TRIP);
    set_level(48'sh3C0);
    wait_cond(COND_NORMAL);
    @(posedge core_clk_i) blk <= 1'b1;
    set_level(48'sh4E20);
    wait_cond(COND_BLOCKED);
    check("blocked_flag", blocked, 64'h1);
    check("time_left", left, 64'h0);
    check("blocks", cnt_b, 64'h1);
    set_level(48'sh0);
    @(posedge core_clk_i) blk <= 1'b0;
    wait_cond(COND_NORMAL);
    set_level(48'sh4E20);
    wait_cond(COND_START);
    @(posedge core_clk_i) blk <= 1'b1;
    wait_cond(COND_NORMAL);
    check("trips", cnt_t, 64'h1);
    check("starts", cnt_s, 64'h2);
    set_level(48'sh0);
    @(posedge core_clk_i) blk <= 1'b0;
    wait_cond(COND_NORMAL);
    @(posedge core_clk_i);
    mode <= CMP_UNDER;
    blim <= -48'sh1388;
    set_level(48'sh1F4);
    wait_cond(COND_START);
    set_level(-48'sh1770);
    wait_cond(COND_NORMAL);
    @(posedge core_clk_i) mode <= CMP_OVER_ABS;
    set_level(-48'sh4E20);
    wait_cond(COND_START);
    set_level(48'sh0);
    wait_cond(COND_NORMAL);
    @(posedge core_clk_i) dflt <= 1'b1;
    set_level(48'sh4E20);
    wait_cond(COND_START);
    check("exp_time", exp_t, 64'h28);
    @(posedge core_clk_i) clr <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    check("starts", cnt_s, 64'h0);
    print_verdict();
  end
  initial begin
    #800000;
    num_errors++;
    print_verdict();
  end
endmodule // pts_stage_tb
